//--- hdl/ppcb_pkg.sv
// Purpose: constants and carriers for the port pin configuration bank
// Assumes: one core clock, special function register access from the core
// Notes: page-F registers decode only with the page select at PAGE_F
// Function
// R1: an analog pin loses its weak pullup, output driver and input receiver.
// R2: port 3 analog select lives at 0xF4 on page F, 0 analog, 1 digital.
// R3: port 4 analog select lives at 0xF5 on page F, 0 analog, 1 digital.
// R4: the output-type bit of a pin is ignored while that pin is analog.
// R5: port 3 output type lives at 0xAF on page F, 0 open-drain, 1 push-pull.
// R6: port 4 output type lives at 0x9A on page F, 0 open-drain, 1 push-pull.
// R7: port 3 drive strength lives at 0xFC on page F, 0 low, 1 high.
// R8: a write to port 4 data at 0xAC loads the output latches bit by bit.
// R9: a read of port 4 data returns the level of each digital pin.
// R10: data registers decode on every page, configuration only on page F.
// R11: port 3 data at 0xB0 is on every page, bit writable, reads pin levels.
// R12: a register updates on the write edge, pads follow the next cycle.
package ppcb_pkg;

   localparam logic [3:0] PAGE_F           = 4'hf;

   localparam logic [7:0] P4_OTYPE_OFS     = 8'h9a;
   localparam logic [7:0] P4_DATA_OFS      = 8'hac;
   localparam logic [7:0] P3_OTYPE_OFS     = 8'haf;
   localparam logic [7:0] P3_DATA_OFS      = 8'hb0;
   localparam logic [7:0] P3_ASEL_OFS      = 8'hf4;
   localparam logic [7:0] P4_ASEL_OFS      = 8'hf5;
   localparam logic [7:0] P3_DRIVE_OFS     = 8'hfc;

   localparam logic [7:0] P4_OTYPE_RST     = 8'h00;
   localparam logic [7:0] P4_DATA_RST      = 8'hff;
   localparam logic [7:0] P3_OTYPE_RST     = 8'h00;
   localparam logic [7:0] P3_DATA_RST      = 8'hff;
   localparam logic [7:0] P3_ASEL_RST      = 8'hff;
   localparam logic [7:0] P4_ASEL_RST      = 8'hff;
   localparam logic [7:0] P3_DRIVE_RST     = 8'h00;
   // port 4 has no drive strength register; its pads take fixed low drive from here
   localparam logic [7:0] P4_DRIVE_FIXED   = 8'h00;
   localparam logic [7:0] SYNC_RST         = 8'h00;
   localparam logic [7:0] RDATA_RST        = 8'h00;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       bit_wr;
      logic [7:0] bit_addr;
      logic       bit_val;
   } ppcb_sfr_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pullup_en;
      logic [7:0] high_drive;
      logic [7:0] analog;
   } ppcb_pad_t;

   localparam ppcb_pad_t PAD_RST = '{out: 8'hff, oe_n: 8'hff,
                                     pullup_en: 8'h00, high_drive: 8'h00,
                                     analog: 8'h00};

endpackage

//--- hdl/ppcb_sync.sv
// Purpose: two-stage synchroniser for eight pad input levels
// Assumes: pads change without regard to the core clock
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module ppcb_sync
(
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_clk_en,
   input  wire logic [7:0] i_async,
   output logic      [7:0] o_sync
);

   logic [7:0] stage1_ff;
   logic [7:0] stage2_ff;

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         stage1_ff <= ppcb_pkg::SYNC_RST;
         stage2_ff <= ppcb_pkg::SYNC_RST;
      end
      else if (i_clk_en)
      begin
         stage1_ff <= i_async;
         stage2_ff <= stage1_ff;
      end
   end

   assign o_sync = stage2_ff;

endmodule

//--- hdl/ppcb_pad_ctl.sv
// Purpose: per-pin pad controls of one eight-pin port
// Assumes: configuration comes from registers on the same clock
// Notes: outputs are registered, so they lag the registers by one cycle
`timescale 1ns/1ps
module ppcb_pad_ctl
(
   input  wire logic                i_core_clk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_clk_en,
   input  wire logic [7:0]          i_latch,
   input  wire logic [7:0]          i_digital,
   input  wire logic [7:0]          i_push_pull,
   input  wire logic [7:0]          i_high_drive,
   output ppcb_pkg::ppcb_pad_t      o_pad
);

   ppcb_pkg::ppcb_pad_t pad_ff;
   ppcb_pkg::ppcb_pad_t nxt_pad;
   wire  [7:0]          drive_en;

   genvar n;
   generate
      for (n = 0; n < 8; n++)
      begin : g_pin
         // open-drain drives only a low; type bit gated by digital mode
         // R4 type ignored if analog
         assign drive_en[n] = i_digital[n] & (i_push_pull[n] | ~i_latch[n]);
      end
   endgenerate

   // R1 analog kills pad paths
   assign nxt_pad = '{out:        i_latch & i_digital,
                      oe_n:       ~drive_en,
                      pullup_en:  i_digital & i_latch,
                      high_drive: i_digital & i_high_drive,
                      analog:     ~i_digital};

   // R12 pads follow next cycle
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         pad_ff <= ppcb_pkg::PAD_RST;
      else if (i_clk_en)
         pad_ff <= nxt_pad;
   end

   assign o_pad = pad_ff;

endmodule

//--- hdl/ppcb_top.sv
// Purpose: register file and pad control for ports 3 and 4
// Assumes: core issues one-cycle wr/rd strobes with address and page
// Notes: read data appears one cycle after rd, with o_sfr_rvalid
`timescale 1ns/1ps
module ppcb_top
(
   input  wire logic                   i_core_clk,
   input  wire logic                   i_sys_rst,
   input  wire logic                   i_clk_en,
   input  wire ppcb_pkg::ppcb_sfr_req_t i_sfr_req,
   output logic [7:0]                  o_sfr_rdata,
   output logic                        o_sfr_rvalid,
   input  wire logic [7:0]             i_port3_pin,
   input  wire logic [7:0]             i_port4_pin,
   output ppcb_pkg::ppcb_pad_t         o_port3_pad,
   output ppcb_pkg::ppcb_pad_t         o_port4_pad
);

   // decode used by write and read paths alike
   function automatic logic sfr_hit
   (
      input ppcb_pkg::ppcb_sfr_req_t r,
      input logic [7:0]              ofs,
      input logic                    paged
   );
      sfr_hit = (r.addr == ofs) && (!paged || r.page == ppcb_pkg::PAGE_F);
   endfunction

   logic [7:0] p3_asel_ff;
   logic [7:0] p4_asel_ff;
   logic [7:0] p3_otype_ff;
   logic [7:0] p4_otype_ff;
   logic [7:0] p3_drive_ff;
   logic [7:0] p3_latch_ff;
   logic [7:0] p4_latch_ff;
   logic [7:0] rdata_ff;
   logic       rvalid_ff;

   wire  [7:0] p3_pin_sync;
   wire  [7:0] p4_pin_sync;

   // R10 data on all pages
   wire hit_p3_data  = sfr_hit(i_sfr_req, ppcb_pkg::P3_DATA_OFS, 1'b0);
   wire hit_p4_data  = sfr_hit(i_sfr_req, ppcb_pkg::P4_DATA_OFS, 1'b0);
   // R10 config only on page F
   wire hit_p3_asel  = sfr_hit(i_sfr_req, ppcb_pkg::P3_ASEL_OFS, 1'b1);
   wire hit_p4_asel  = sfr_hit(i_sfr_req, ppcb_pkg::P4_ASEL_OFS, 1'b1);
   wire hit_p3_otype = sfr_hit(i_sfr_req, ppcb_pkg::P3_OTYPE_OFS, 1'b1);
   wire hit_p4_otype = sfr_hit(i_sfr_req, ppcb_pkg::P4_OTYPE_OFS, 1'b1);
   wire hit_p3_drive = sfr_hit(i_sfr_req, ppcb_pkg::P3_DRIVE_OFS, 1'b1);

   wire wr = i_sfr_req.wr;
   wire rd = i_sfr_req.rd;

   // R2 port 3 analog select
   wire [7:0] nxt_p3_asel  = (wr && hit_p3_asel) ? i_sfr_req.wdata
                                                  : p3_asel_ff;
   // R3 port 4 analog select
   wire [7:0] nxt_p4_asel  = (wr && hit_p4_asel) ? i_sfr_req.wdata
                                                  : p4_asel_ff;
   // R5 port 3 output type
   wire [7:0] nxt_p3_otype = (wr && hit_p3_otype) ? i_sfr_req.wdata
                                                   : p3_otype_ff;
   // R6 port 4 output type
   wire [7:0] nxt_p4_otype = (wr && hit_p4_otype) ? i_sfr_req.wdata
                                                   : p4_otype_ff;
   // R7 port 3 drive strength
   wire [7:0] nxt_p3_drive = (wr && hit_p3_drive) ? i_sfr_req.wdata
                                                   : p3_drive_ff;
   // R8 port 4 latch load
   wire [7:0] nxt_p4_latch = (wr && hit_p4_data) ? i_sfr_req.wdata
                                                  : p4_latch_ff;

   // R11 bit write to port 3 latch
   wire       hit_p3_bit   = i_sfr_req.bit_wr &&
                 (i_sfr_req.bit_addr[7:3] == ppcb_pkg::P3_DATA_OFS[7:3]);
   wire [7:0] bit_mask     = 8'h01 << i_sfr_req.bit_addr[2:0];
   wire [7:0] p3_bit_upd   = (p3_latch_ff & ~bit_mask) |
                             (i_sfr_req.bit_val ? bit_mask : 8'h00);
   // byte write wins if both arrive together
   wire [7:0] nxt_p3_latch = (wr && hit_p3_data) ? i_sfr_req.wdata :
                             hit_p3_bit          ? p3_bit_upd
                                                 : p3_latch_ff;

   // receiver off in analog mode, so those bits read low
   // R9 read pin levels
   wire [7:0] p4_pin_view  = p4_pin_sync & p4_asel_ff;
   // R11 port 3 reads pins
   wire [7:0] p3_pin_view  = p3_pin_sync & p3_asel_ff;

   // unmapped or off-page reads return zero
   wire [7:0] rd_mux = hit_p3_data  ? p3_pin_view :
                       hit_p4_data  ? p4_pin_view :
                       hit_p3_asel  ? p3_asel_ff  :
                       hit_p4_asel  ? p4_asel_ff  :
                       hit_p3_otype ? p3_otype_ff :
                       hit_p4_otype ? p4_otype_ff :
                       hit_p3_drive ? p3_drive_ff : 8'h00;
   wire [7:0] nxt_rdata = rd ? rd_mux : rdata_ff;

   // R12 update on write edge
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         p3_asel_ff  <= ppcb_pkg::P3_ASEL_RST;
         p4_asel_ff  <= ppcb_pkg::P4_ASEL_RST;
         p3_otype_ff <= ppcb_pkg::P3_OTYPE_RST;
         p4_otype_ff <= ppcb_pkg::P4_OTYPE_RST;
         p3_drive_ff <= ppcb_pkg::P3_DRIVE_RST;
         p3_latch_ff <= ppcb_pkg::P3_DATA_RST;
         p4_latch_ff <= ppcb_pkg::P4_DATA_RST;
      end
      else if (i_clk_en)
      begin
         p3_asel_ff  <= nxt_p3_asel;
         p4_asel_ff  <= nxt_p4_asel;
         p3_otype_ff <= nxt_p3_otype;
         p4_otype_ff <= nxt_p4_otype;
         p3_drive_ff <= nxt_p3_drive;
         p3_latch_ff <= nxt_p3_latch;
         p4_latch_ff <= nxt_p4_latch;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         rdata_ff  <= ppcb_pkg::RDATA_RST;
         rvalid_ff <= 1'b0;
      end
      else if (i_clk_en)
      begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= rd;
      end
   end

   assign o_sfr_rdata  = rdata_ff;
   assign o_sfr_rvalid = rvalid_ff;

   // pads are asynchronous to the core clock
   ppcb_sync u_p3_sync
   (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_clk_en   (i_clk_en),
      .i_async    (i_port3_pin),
      .o_sync     (p3_pin_sync)
   );

   ppcb_sync u_p4_sync
   (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_clk_en   (i_clk_en),
      .i_async    (i_port4_pin),
      .o_sync     (p4_pin_sync)
   );

   ppcb_pad_ctl u_p3_pad
   (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_clk_en     (i_clk_en),
      .i_latch      (p3_latch_ff),
      .i_digital    (p3_asel_ff),
      .i_push_pull  (p3_otype_ff),
      .i_high_drive (p3_drive_ff),
      .o_pad        (o_port3_pad)
   );

   ppcb_pad_ctl u_p4_pad
   (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_clk_en     (i_clk_en),
      .i_latch      (p4_latch_ff),
      .i_digital    (p4_asel_ff),
      .i_push_pull  (p4_otype_ff),
      .i_high_drive (ppcb_pkg::P4_DRIVE_FIXED),
      .o_pad        (o_port4_pad)
   );

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   p3_asel_write_a: assert property ( // R2
      i_clk_en && wr && i_sfr_req.addr == 8'hf4 && i_sfr_req.page == 4'hf
      |=> p3_asel_ff == $past(i_sfr_req.wdata))
      else $error("port 3 analog select not loaded");

   p4_asel_write_a: assert property ( // R3
      i_clk_en && wr && i_sfr_req.addr == 8'hf5 && i_sfr_req.page == 4'hf
      |=> p4_asel_ff == $past(i_sfr_req.wdata))
      else $error("port 4 analog select not loaded");

   p3_otype_write_a: assert property ( // R5
      i_clk_en && wr && i_sfr_req.addr == 8'haf && i_sfr_req.page == 4'hf
      |=> p3_otype_ff == $past(i_sfr_req.wdata))
      else $error("port 3 output type not loaded");

   p4_otype_write_a: assert property ( // R6
      i_clk_en && wr && i_sfr_req.addr == 8'h9a && i_sfr_req.page == 4'hf
      |=> p4_otype_ff == $past(i_sfr_req.wdata))
      else $error("port 4 output type not loaded");

   p3_drive_write_a: assert property ( // R7
      i_clk_en && wr && i_sfr_req.addr == 8'hfc && i_sfr_req.page == 4'hf
      |=> ##1 o_port3_pad.high_drive == ($past(i_sfr_req.wdata, 2)
                                         & $past(p3_asel_ff)))
      else $error("port 3 drive strength not at pad");

   p4_latch_any_page_a: assert property ( // R8
      i_clk_en && wr && i_sfr_req.addr == 8'hac
      |=> p4_latch_ff == $past(i_sfr_req.wdata))
      else $error("port 4 latch not loaded");

   cfg_off_page_a: assert property ( // R10
      i_clk_en && i_sfr_req.addr == 8'hf4 && i_sfr_req.page != 4'hf
      |=> $stable(p3_asel_ff))
      else $error("config register written off page F");

   p4_pin_read_a: assert property ( // R9
      i_clk_en && rd && i_sfr_req.addr == 8'hac
      |=> o_sfr_rvalid && o_sfr_rdata == ($past(p4_pin_sync)
                                           & $past(p4_asel_ff)))
      else $error("port 4 read not pin level");

   p3_bit_write_a: assert property ( // R11
      i_clk_en && hit_p3_bit && !(wr && hit_p3_data)
      |=> p3_latch_ff[$past(i_sfr_req.bit_addr[2:0])]
          == $past(i_sfr_req.bit_val))
      else $error("port 3 bit write lost");

   p3_drive_gate_a: assert property ( // R4
      i_clk_en |=> o_port3_pad.oe_n == ~($past(p3_asel_ff)
                   & ($past(p3_otype_ff) | ~$past(p3_latch_ff))))
      else $error("port 3 driver enable wrong");

   analog_pad_off_a: assert property ( // R1
      i_clk_en |=> ((o_port4_pad.pullup_en | ~o_port4_pad.oe_n)
                    & ~$past(p4_asel_ff)) == 8'h00
                   && o_port4_pad.analog == ~$past(p4_asel_ff))
      else $error("analog pin kept digital paths");

   pad_lag_a: assert property ( // R12
      i_clk_en && wr && i_sfr_req.addr == 8'hf5 && i_sfr_req.page == 4'hf
      ##1 i_clk_en |=> o_port4_pad.analog == ~$past(i_sfr_req.wdata, 2))
      else $error("pad did not follow write next cycle");

   cov_analog_c:    cover property (i_clk_en && wr && hit_p3_asel
                                    && i_sfr_req.wdata != 8'hff);
   cov_bit_wr_c:    cover property (i_clk_en && hit_p3_bit);
   cov_pin_read_c:  cover property (i_clk_en && rd && hit_p3_data
                                    ##1 o_sfr_rdata != 8'h00);
   cov_push_pull_c: cover property (o_port4_pad.oe_n != 8'hff);

endmodule

//--- bench/ppcb_core_model.sv
// Purpose: core-side model issuing register requests
// Assumes: one request at a time, strobes held for one cycle
// Notes: read data is taken just after the edge that answers
`timescale 1ns/1ps
module ppcb_core_model
(
   input  wire logic               i_core_clk,
   input  wire logic [7:0]         i_rdata,
   input  wire logic               i_rvalid,
   output ppcb_pkg::ppcb_sfr_req_t o_req
);
   initial o_req = '0;

   task automatic issue(input ppcb_pkg::ppcb_sfr_req_t q,
                        output logic [7:0] got, output logic ok);
      @(posedge i_core_clk);
      o_req <= q;
      @(posedge i_core_clk);
      o_req <= '0;
      // answer lands on the edge that takes the request
      #1;
      got = i_rdata;
      ok = i_rvalid;
   endtask
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for the port configuration bank
// Assumes: clock enable held high except in the clock_freeze test, pins settle three cycles before reads
// Notes: expectations come from a register-array model
`timescale 1ns/1ps
module tb;
   logic                    i_core_clk = 1'b0;
   logic                    i_sys_rst  = 1'b1;
   logic                    clk_en     = 1'b1;
   logic [7:0]              p3_pin     = 8'h00;
   logic [7:0]              p4_pin     = 8'h00;
   ppcb_pkg::ppcb_sfr_req_t req;
   logic [7:0]              rdata;
   logic                    rvalid;
   ppcb_pkg::ppcb_pad_t     pad3;
   ppcb_pkg::ppcb_pad_t     pad4;
   int                      err_count = 0;
   int                      n_checks  = 0;
   logic [7:0]              mr [256];
   logic [7:0]              cfg [5] = '{8'hf4, 8'hf5, 8'haf, 8'h9a, 8'hfc};

   always #5 i_core_clk = ~i_core_clk;

   ppcb_top ppcb_top_i
   (
      .i_core_clk  (i_core_clk),
      .i_sys_rst   (i_sys_rst),
      .i_clk_en    (clk_en),
      .i_sfr_req   (req),
      .o_sfr_rdata (rdata),
      .o_sfr_rvalid(rvalid),
      .i_port3_pin (p3_pin),
      .i_port4_pin (p4_pin),
      .o_port3_pad (pad3),
      .o_port4_pad (pad4)
   );

   ppcb_core_model core_i
   (
      .i_core_clk(i_core_clk),
      .i_rdata   (rdata),
      .i_rvalid  (rvalid),
      .o_req     (req)
   );

   function automatic logic [7:0] exp_rd(logic [3:0] pg, logic [7:0] ad);
      // analog pins read low: receiver off
      if (ad == 8'hac)
         return p4_pin & mr[8'hf5];
      if (ad == 8'hb0)
         return p3_pin & mr[8'hf4];
      if (pg == 4'hf && ad inside {cfg})
         return mr[ad];
      return 8'h00;
   endfunction

   function automatic ppcb_pkg::ppcb_pad_t exp_pad(logic [7:0] dg,
      logic [7:0] lt, logic [7:0] ty, logic [7:0] dv);
      logic [7:0] drv;
      drv = dg & (ty | ~lt);
      return '{out: lt & dg, oe_n: ~drv, pullup_en: dg & lt,
               high_drive: dg & dv, analog: ~dg};
   endfunction

   task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
         err_count++;
      end
   endtask

   task automatic access(input logic w, input logic r, input logic b,
      input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] wd);
      ppcb_pkg::ppcb_sfr_req_t q;
      logic [7:0]              got;
      logic                    ok;
      logic [7:0]              ex;
      q = '0;
      q.wr = w;
      q.rd = r;
      q.page = pg;
      q.addr = ad;
      q.wdata = wd;
      q.bit_wr = b;
      q.bit_addr = ad;
      q.bit_val = wd[0];
      // expectation taken first: a read beside a write sees the old value
      ex = exp_rd(pg, ad);
      core_i.issue(q, got, ok);
      if (r)
      begin
         chk(40'(ok), 40'h1, "rvalid");
         chk(40'(got), 40'(ex), "rdata");
      end
      // a request taken while frozen must leave every register alone
      if (clk_en && w &&
          (ad inside {8'hac, 8'hb0} || (pg == 4'hf && ad inside {cfg})))
         mr[ad] = wd;
      if (clk_en && b && ad[7:3] == 5'h16)
         mr[8'hb0][ad[2:0]] = wd[0];
   endtask

   task automatic chk_pads();
      chk(pad3, exp_pad(mr[8'hf4], mr[8'hb0], mr[8'haf], mr[8'hfc]),
          "port3 pad");
      chk(pad4, exp_pad(mr[8'hf5], mr[8'hac], mr[8'h9a], 8'h00),
          "port4 pad");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      mr = '{default: 8'h00};
      mr[8'hf4] = 8'hff;
      mr[8'hf5] = 8'hff;
      mr[8'hac] = 8'hff;
      mr[8'hb0] = 8'hff;
      void'($urandom(22965));
      repeat (3) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      foreach (cfg[i]) access(0, 1, 0, 4'hf, cfg[i], 8'h00);
      chk_pads();
      $display("test reset_values done");
      repeat (20)
      begin
         foreach (cfg[i]) access(1, 0, 0, 4'hf, cfg[i], 8'($urandom));
         // off-page writes must leave settings alone
         foreach (cfg[i]) access(1, 1, 0, 4'($urandom_range(14)), cfg[i],
                                 8'($urandom));
         access(1, 1, 0, 4'hf, cfg[$urandom_range(4)], 8'($urandom));
         access(1, 1, 0, 4'hf, 8'h55, 8'($urandom));
         access(1, 0, 0, 4'($urandom), 8'hac, 8'($urandom));
         access(1, 0, 0, 4'($urandom), 8'hb0, 8'($urandom));
         access(0, 0, 1, 4'($urandom), 8'hb0 + 8'($urandom_range(7)),
                8'($urandom));
         @(posedge i_core_clk);
         p3_pin <= 8'($urandom);
         p4_pin <= 8'($urandom);
         repeat (3) @(posedge i_core_clk);
         chk_pads();
         foreach (cfg[i]) access(0, 1, 0, 4'hf, cfg[i], 8'h00);
         access(0, 1, 0, 4'($urandom), 8'hac, 8'h00);
         access(0, 1, 0, 4'($urandom), 8'hb0, 8'h00);
      end
      $display("test random_config done");
      @(posedge i_core_clk);
      clk_en <= 1'b0;
      access(1, 0, 0, 4'hf, 8'hf4, 8'($urandom));
      @(posedge i_core_clk);
      clk_en <= 1'b1;
      access(0, 1, 0, 4'hf, 8'hf4, 8'h00);
      $display("test clock_freeze done");
      for (int i = 0; i < 8; i++)
         access(0, 0, 1, 4'h0, 8'hb0 + 8'(i), 8'(i));
      repeat (2) @(posedge i_core_clk);
      chk_pads();
      $display("test bit_writes done");
      stop_test();
   end

   initial
   begin
      #100us;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
endmodule
